// ===== dv/ntpo_host.sv
module ntpo_host (
  // Clock
  input  wire logic       clk_i,
  // Register port
  output logic      [6:0] reg_addr_o,
  output logic            reg_wr_o,
  output logic      [7:0] reg_wdata_o,
  output logic            reg_rd_o,
  input  wire logic [7:0] reg_rdata_i
);
  timeunit 1ns;
  timeprecision 1ps;
  // Idle port from time zero
  initial {reg_addr_o, reg_wr_o, reg_wdata_o, reg_rd_o} = 17'h00000;
  // Byte write, strobe held across one rising edge
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    @(negedge clk_i);
    {reg_addr_o, reg_wdata_o, reg_wr_o} = {a, d, 1'b1};
    @(negedge clk_i);
    reg_wr_o = 1'b0;
  endtask
  // Byte read, data taken once settled
  task automatic rd(input logic [6:0] a, output logic [7:0] d);
    @(negedge clk_i);
    {reg_addr_o, reg_rd_o} = {a, 1'b1};
    @(negedge clk_i);
    reg_rd_o = 1'b0;
    @(negedge clk_i);
    d = reg_rdata_i;
  endtask
  // Tuning update request, cleared then set
  task automatic upd();
    wr(7'h36, 8'h00);
    wr(7'h36, 8'h01);
  endtask
endmodule // ntpo_host

// ===== dv/ntpo_regs_assertions.sv
`include "ntpo_defs.vh"
module ntpo_chk (
  // Clock and reset
  input wire logic        clk_i,
  input wire logic        sys_rst_i,
  // Register port and outputs
  input wire logic [6:0]  reg_addr_i,
  input wire logic        reg_wr_i,
  input wire logic [7:0]  reg_wdata_i,
  input wire logic        reg_rd_i,
  input wire logic [7:0]  reg_rdata_o,
  input wire logic [31:0] tuning_word_o,
  input wire logic        osc_reset_o,
  input wire logic [15:0] osc_start_phase_o,
  input wire logic [9:0]  i_phase_adj_o,
  input wire logic        third_filter_skip_o,
  input wire logic        third_filter_modulate_o,
  input wire logic [5:0]  third_filter_mode_o,
  input wire logic        i_valid_i,
  input wire logic        i_valid_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic req_ff;
  wire  upd_w;
  // Shadow of the stored update request bit
  always_ff @(posedge clk_i or posedge sys_rst_i)
    if (sys_rst_i) req_ff <= 1'b0;
    else if (reg_wr_i && reg_addr_i == 7'h36) req_ff <= reg_wdata_i[0];
  assign upd_w = reg_wr_i && reg_addr_i == 7'h36 && reg_wdata_i[0] && !req_ff;
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (sys_rst_i);
  // Tuning word moves only on a request rising edge
  property p_tw; !upd_w |=> $stable(tuning_word_o); endproperty
  a_tw: assert property (p_tw) else $error("tuning word moved");
  property p_id; reg_rd_i && reg_addr_i == 7'h1F |=> reg_rdata_o == `NTPO_DEV_ID_VAL;
  endproperty
  a_id: assert property (p_id) else $error("id value wrong");
  property p_ph; reg_wr_i && reg_addr_i == 7'h34 |=> ##1
    osc_start_phase_o[7:0] == $past(reg_wdata_i, 2); endproperty
  a_ph: assert property (p_ph) else $error("start phase low byte wrong");
  property p_adj; reg_wr_i && reg_addr_i == 7'h39 |=> ##1
    i_phase_adj_o[9:8] == $past(reg_wdata_i[1:0], 2); endproperty
  a_adj: assert property (p_adj) else $error("i phase adjust high wrong");
  property p_skip; reg_wr_i && reg_addr_i == 7'h1E |=> ##1
    third_filter_skip_o == $past(reg_wdata_i[0], 2); endproperty
  a_skip: assert property (p_skip) else $error("filter skip wrong");
  property p_mod; third_filter_mode_o == `NTPO_MODE_HI_A ||
    third_filter_mode_o == `NTPO_MODE_HI_B |-> third_filter_modulate_o; endproperty
  a_mod: assert property (p_mod) else $error("modulate flag wrong");
  property p_mode; reg_wr_i && reg_addr_i == 7'h1E |=> ##1
    third_filter_mode_o == $past(reg_wdata_i[6:1], 2); endproperty
  a_mode: assert property (p_mode) else $error("filter mode wrong");
  property p_osc; osc_reset_o |=> !osc_reset_o; endproperty
  a_osc: assert property (p_osc) else $error("oscillator reset too long");
  property p_iv; i_valid_i |=> i_valid_o; endproperty
  a_iv: assert property (p_iv) else $error("sample valid lost");
endmodule // ntpo_chk

bind ntpo_regs ntpo_chk u_chk (
  .clk_i(clk_i), .sys_rst_i(sys_rst_i), .reg_addr_i(reg_addr_i), .reg_wr_i(reg_wr_i),
  .reg_wdata_i(reg_wdata_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
  .tuning_word_o(tuning_word_o), .osc_reset_o(osc_reset_o),
  .osc_start_phase_o(osc_start_phase_o), .i_phase_adj_o(i_phase_adj_o),
  .third_filter_skip_o(third_filter_skip_o),
  .third_filter_modulate_o(third_filter_modulate_o),
  .third_filter_mode_o(third_filter_mode_o), .i_valid_i(i_valid_i), .i_valid_o(i_valid_o));

// ===== dv/tb_top.sv
`include "ntpo_defs.vh"
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk_i, sys_rst_i, frame_i, i_valid_i, reg_wr, reg_rd, oscr, skip, modu, ivo;
  logic [6:0]  reg_addr;
  logic [7:0]  reg_wdata, reg_rdata;
  logic [5:0]  mode;
  logic [9:0]  iadj, qadj;
  logic [15:0] i_sample_i, ph, php, iso;
  logic [31:0] tw;
  int          n_errors, num_checks, n_osc, cyc, t, mdl[int];
  int          ra[16] = '{8'h1E, 8'h1F, 8'h30, 8'h31, 8'h32, 8'h33, 8'h34, 8'h35,
                          8'h36, 8'h37, 8'h38, 8'h39, 8'h3A, 8'h3B, 8'h3C, 8'h3D};
  logic [5:0]  mc[3] = '{6'h36, 6'h3F, 6'h09}; // Two modulated codes, then a plain one
  ntpo_regs dut (
    .clk_i(clk_i), .sys_rst_i(sys_rst_i), .reg_addr_i(reg_addr), .reg_wr_i(reg_wr),
    .reg_wdata_i(reg_wdata), .reg_rd_i(reg_rd), .reg_rdata_o(reg_rdata), .frame_i(frame_i),
    .tuning_word_o(tw), .osc_reset_o(oscr), .osc_start_phase_o(ph), .i_phase_adj_o(iadj),
    .q_phase_adj_o(qadj), .third_filter_skip_o(skip), .third_filter_modulate_o(modu),
    .third_filter_mode_o(mode), .i_valid_i(i_valid_i), .i_sample_i(i_sample_i),
    .i_valid_o(ivo), .i_sample_o(iso));
  ntpo_host u_host (.clk_i(clk_i), .reg_addr_o(reg_addr), .reg_wr_o(reg_wr),
    .reg_wdata_o(reg_wdata), .reg_rd_o(reg_rd), .reg_rdata_i(reg_rdata));
  // Clock
  initial begin
    clk_i = 1'b0;
    forever #10 clk_i = ~clk_i;
  end
  // Oscillator reset monitor and hang limit
  always @(posedge clk_i) begin
    cyc <= cyc + 1;
    if (oscr === 1'b1) begin
      n_osc++;
      php = ph;
    end
    if (cyc == 3000) begin
      n_errors++;
      finish_test();
    end
  end
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      n_errors++;
      $display("unexpected %s exp %0h got %0h", nm, e, g);
    end
  endtask
  task automatic finish_test();
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  // Readback value expected after writing d
  function automatic int exp_rd(int a, int d);
    if (a == 8'h1F) return `NTPO_DEV_ID_VAL;
    if (a == 8'h37) return 0;
    if (a == 8'h1E) return d & 8'h7F;
    if (a == 8'h39 || a == 8'h3B) return d & 8'h03;
    return d & 8'hFF;
  endfunction
  function automatic int w16(int a);
    return mdl[a + 1] * 256 + mdl[a];
  endfunction
  task automatic wrm(input int a);
    int d;
    d = $urandom & 8'hFF;
    mdl[a] = exp_rd(a, d);
    u_host.wr(a[6:0], d[7:0]);
  endtask
  task automatic rdchk(input int a, input int e);
    logic [7:0] d;
    u_host.rd(a[6:0], d);
    chk("rdata", e, d);
  endtask
  task automatic pulse(input int n);
    @(negedge clk_i);
    frame_i = 1'b1;
    repeat (n) @(negedge clk_i);
    frame_i = 1'b0;
    repeat (20) @(negedge clk_i);
  endtask
  // Main sequence
  initial begin
    {sys_rst_i, frame_i, i_valid_i, i_sample_i} = 19'h40000;
    t = $urandom(32'h2D53);
    repeat (4) @(posedge clk_i);
    @(negedge clk_i);
    sys_rst_i = 1'b0;
    foreach (ra[k]) rdchk(ra[k], (ra[k] == 8'h1F) ? `NTPO_DEV_ID_VAL : 0);
    foreach (ra[k]) if (ra[k] != 8'h36) wrm(ra[k]);
    foreach (ra[k]) if (ra[k] != 8'h36) rdchk(ra[k], mdl[ra[k]]);
    chk("tw", 0, tw);
    chk("ph", w16(8'h34), ph);
    chk("iadj", w16(8'h38), iadj);
    chk("qadj", w16(8'h3A), qadj);
    // Tuning word update handshake
    u_host.wr(7'h36, 8'h01);
    rdchk(8'h36, 8'h03);
    t = w16(8'h30) + w16(8'h32) * 65536;
    chk("tw", t, tw);
    for (int a = 8'h30; a < 8'h34; a++) wrm(a);
    u_host.wr(7'h36, 8'h01);
    chk("tw", t, tw);
    u_host.wr(7'h36, 8'h22);
    rdchk(8'h36, 8'h00);
    u_host.upd();
    rdchk(8'h36, 8'h03);
    chk("tw", w16(8'h30) + w16(8'h32) * 65536, tw);
    // Frame-triggered oscillator reset
    u_host.wr(7'h36, 8'h10);
    pulse(2);
    chk("osc", 0, n_osc);
    pulse(10);
    chk("osc", 1, n_osc);
    chk("php", w16(8'h34), php);
    rdchk(8'h36, 8'h30);
    u_host.wr(7'h36, 8'h00);
    pulse(10);
    chk("osc", 1, n_osc);
    // Back-to-back samples through the offset adder
    for (int k = 0; k < 9; k++) begin
      @(negedge clk_i);
      if (k > 0) chk("smp", 32'h10000 | ((t + w16(8'h3C)) & 16'hFFFF), {ivo, iso});
      t = $urandom;
      i_valid_i = k < 8;
      i_sample_i = t[15:0];
    end
    // Filter mode codes and skip bit
    foreach (mc[k]) begin
      u_host.wr(7'h1E, {1'b0, mc[k], k[0]});
      repeat (2) @(negedge clk_i);
      chk("mode", {mc[k], (k < 2), k[0]}, {mode, modu, skip});
    end
    finish_test();
  end
endmodule // tb_top

// ===== src/ntpo_defs.vh
`ifndef NTPO_DEFS_VH
`define NTPO_DEFS_VH
// Register addresses
`define NTPO_ADDR_FILT_CTRL  7'h1E
`define NTPO_ADDR_DEV_ID     7'h1F
`define NTPO_ADDR_TW0        7'h30
`define NTPO_ADDR_TW1        7'h31
`define NTPO_ADDR_TW2        7'h32
`define NTPO_ADDR_TW3        7'h33
`define NTPO_ADDR_PH_LO      7'h34
`define NTPO_ADDR_PH_HI      7'h35
`define NTPO_ADDR_UPD        7'h36
`define NTPO_ADDR_IPA_LO     7'h38
`define NTPO_ADDR_IPA_HI     7'h39
`define NTPO_ADDR_QPA_LO     7'h3A
`define NTPO_ADDR_QPA_HI     7'h3B
`define NTPO_ADDR_IOFS_LO    7'h3C
`define NTPO_ADDR_IOFS_HI    7'h3D
// Field positions in the update register
`define NTPO_UPD_REQ_BIT     0
`define NTPO_UPD_ACK_BIT     1
`define NTPO_FRM_REQ_BIT     4
`define NTPO_FRM_ACK_BIT     5
// Field positions in the third filter control register
`define NTPO_SKIP_BIT        0
`define NTPO_MODE_MSB        6
`define NTPO_MODE_LSB        1
// Third filter mode codes
`define NTPO_MODE_HI_A       6'h36
`define NTPO_MODE_HI_B       6'h3F
// Reset values
`define NTPO_RST_BYTE        8'h00
`define NTPO_RST_MODE        6'h00
// Identification value, arbitrary
`define NTPO_DEV_ID_VAL      8'hA5
// Frame pulse length that counts as extended, in clocks
`define NTPO_FRAME_EXT_CYC   4'h4
`endif

// ===== src/ntpo_pulse_sync.v
`include "ntpo_defs.vh"
// Three-stage synchroniser with agreement filter and extended-pulse detect
module ntpo_pulse_sync #(
  parameter CNT_W = 4
) (
  // Clock and reset
  input  wire             clk_i,
  input  wire             sys_rst_i,
  // Pin side
  input  wire             pin_i,
  // Result
  output reg              level_o,
  output reg              ext_start_o
);
  reg  [2:0]       sync_ff;
  reg  [CNT_W-1:0] len_ff;

  // Pin resynchronisation
  always @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      sync_ff <= 3'h0;
    end else begin
      sync_ff <= {sync_ff[1:0], pin_i};
    end
  end

  // Level follows once stages two and three agree; count high length
  always @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      level_o     <= 1'b0;
      len_ff      <= {CNT_W{1'b0}};
      ext_start_o <= 1'b0;
    end else begin
      ext_start_o <= 1'b0;
      if (sync_ff[1] == sync_ff[2]) begin
        level_o <= sync_ff[2];
      end
      if (!level_o) begin
        len_ff <= {CNT_W{1'b0}};
      end else if (len_ff != `NTPO_FRAME_EXT_CYC) begin
        len_ff <= len_ff + {{(CNT_W-1){1'b0}}, 1'b1};
        if (len_ff == `NTPO_FRAME_EXT_CYC - 4'h1) begin
          ext_start_o <= 1'b1;
        end
      end
    end
  end
endmodule // ntpo_pulse_sync

// ===== src/ntpo_regs.v
`include "ntpo_defs.vh"
// Overview of operation
// - Mode 110110/111111 modulate, high passbands; code sets modulate for every mode with the top mode bit set
// - Skip bit routes around third filter
// - Fixed identification byte at 0x1F
// - Tuning word from 0x30..0x33, LSB first
// - Byte writes alone leave frequency unchanged
// - Apply word only on request rising edge
// - Set update acknowledge after applying word
// - Frame request resets oscillator on extended frame
// - Set frame acknowledge after that reset
// - Load start phase on oscillator reset
// - Start phase is two's complement
// - Ten-bit I phase adjustment from 0x38/0x39
// - Ten-bit Q phase adjustment from 0x3A/0x3B
// - Add I offset to each I sample
module ntpo_regs #(
  parameter DATA_W = 16
) (
  // Clock and reset
  input  wire              clk_i,
  input  wire              sys_rst_i,
  // Register port from serial control decoder
  input  wire [6:0]        reg_addr_i,
  input  wire              reg_wr_i,
  input  wire [7:0]        reg_wdata_i,
  input  wire              reg_rd_i,
  output reg  [7:0]        reg_rdata_o,
  // Frame pin
  input  wire              frame_i,
  // Oscillator controls
  output reg  [31:0]       tuning_word_o,
  output reg               osc_reset_o,
  output reg  [15:0]       osc_start_phase_o,
  output reg  [9:0]        i_phase_adj_o,
  output reg  [9:0]        q_phase_adj_o,
  // Third filter controls
  output reg               third_filter_skip_o,
  output reg               third_filter_modulate_o,
  output reg  [5:0]        third_filter_mode_o,
  // I sample path
  input  wire              i_valid_i,
  input  wire [DATA_W-1:0] i_sample_i,
  output reg               i_valid_o,
  output reg  [DATA_W-1:0] i_sample_o
);
  reg  [7:0]  fctl_ff;
  reg  [7:0]  tw_ff [0:3];
  reg  [7:0]  ph_lo_ff;
  reg  [7:0]  ph_hi_ff;
  reg         upd_req_ff;
  reg         upd_ack_ff;
  reg         frm_req_ff;
  reg         frm_ack_ff;
  reg  [7:0]  ipa_lo_ff;
  reg  [1:0]  ipa_hi_ff;
  reg  [7:0]  qpa_lo_ff;
  reg  [1:0]  qpa_hi_ff;
  reg  [7:0]  iofs_lo_ff;
  reg  [7:0]  iofs_hi_ff;
  reg  [7:0]  nxt_rdata;
  wire        frame_ext;
  wire        wr_upd;
  wire        upd_rise;
  wire        frm_fire;
  wire [31:0] staged_word;
  wire [15:0] i_offset;

  // Write strobe decode
  function wr_hit;
    input [6:0] addr;
    begin
      wr_hit = reg_wr_i && (reg_addr_i == addr);
    end
  endfunction

  // Frame pin conditioning
  ntpo_pulse_sync #(
    .CNT_W(4)
  ) u_frame (
    .clk_i       (clk_i),
    .sys_rst_i   (sys_rst_i),
    .pin_i       (frame_i),
    .level_o     (),
    .ext_start_o (frame_ext)
  );

  assign wr_upd      = wr_hit(`NTPO_ADDR_UPD);
  assign upd_rise    = wr_upd && reg_wdata_i[`NTPO_UPD_REQ_BIT] && !upd_req_ff;
  assign frm_fire    = frm_req_ff && frame_ext;
  assign staged_word = {tw_ff[3], tw_ff[2], tw_ff[1], tw_ff[0]};
  assign i_offset    = {iofs_hi_ff, iofs_lo_ff};

  // Byte-wide tuning word staging registers
  genvar g;
  generate
    for (g = 0; g < 4; g = g + 1) begin : g_tw
      // Byte address, cut to the port width on purpose
      localparam [31:0] TW_ADDR = `NTPO_ADDR_TW0 + g;
      always @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
          tw_ff[g] <= `NTPO_RST_BYTE;
        end else if (wr_hit(TW_ADDR[6:0])) begin
          tw_ff[g] <= reg_wdata_i;
        end
      end
    end
  endgenerate

  // Third filter control byte; bit 7 is not implemented and reads 0
  always @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      fctl_ff <= `NTPO_RST_BYTE;
    end else if (wr_hit(`NTPO_ADDR_FILT_CTRL)) begin
      fctl_ff <= {1'b0, reg_wdata_i[6:0]};
    end
  end

  // Oscillator start phase bytes
  always @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      ph_lo_ff <= `NTPO_RST_BYTE;
      ph_hi_ff <= `NTPO_RST_BYTE;
    end else begin
      if (wr_hit(`NTPO_ADDR_PH_LO)) begin
        ph_lo_ff <= reg_wdata_i;
      end
      if (wr_hit(`NTPO_ADDR_PH_HI)) begin
        ph_hi_ff <= reg_wdata_i;
      end
    end
  end

  // I path phase adjustment; only two bits of the high byte exist
  always @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      ipa_lo_ff <= `NTPO_RST_BYTE;
      ipa_hi_ff <= 2'h0;
    end else begin
      if (wr_hit(`NTPO_ADDR_IPA_LO)) begin
        ipa_lo_ff <= reg_wdata_i;
      end
      if (wr_hit(`NTPO_ADDR_IPA_HI)) begin
        ipa_hi_ff <= reg_wdata_i[1:0];
      end
    end
  end

  // Q path phase adjustment; only two bits of the high byte exist
  always @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      qpa_lo_ff <= `NTPO_RST_BYTE;
      qpa_hi_ff <= 2'h0;
    end else begin
      if (wr_hit(`NTPO_ADDR_QPA_LO)) begin
        qpa_lo_ff <= reg_wdata_i;
      end
      if (wr_hit(`NTPO_ADDR_QPA_HI)) begin
        qpa_hi_ff <= reg_wdata_i[1:0];
      end
    end
  end

  // I sample offset bytes
  always @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      iofs_lo_ff <= `NTPO_RST_BYTE;
      iofs_hi_ff <= `NTPO_RST_BYTE;
    end else begin
      if (wr_hit(`NTPO_ADDR_IOFS_LO)) begin
        iofs_lo_ff <= reg_wdata_i;
      end
      if (wr_hit(`NTPO_ADDR_IOFS_HI)) begin
        iofs_hi_ff <= reg_wdata_i;
      end
    end
  end

  // Tuning update request written, acknowledge set by hardware only
  always @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      upd_req_ff <= 1'b0;
      upd_ack_ff <= 1'b0;
    end else begin
      if (wr_upd) begin
        upd_req_ff <= reg_wdata_i[`NTPO_UPD_REQ_BIT];
      end
      // Host clears the acknowledge by clearing its request; set wins
      if (wr_upd && !reg_wdata_i[`NTPO_UPD_REQ_BIT]) begin
        upd_ack_ff <= 1'b0;
      end
      if (upd_rise) begin
        upd_ack_ff <= 1'b1;
      end
    end
  end

  // Frame reset request written, acknowledge set by hardware only
  always @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      frm_req_ff <= 1'b0;
      frm_ack_ff <= 1'b0;
    end else begin
      if (wr_upd) begin
        frm_req_ff <= reg_wdata_i[`NTPO_FRM_REQ_BIT];
      end
      // Same clearing scheme as the tuning update; set wins
      if (wr_upd && !reg_wdata_i[`NTPO_FRM_REQ_BIT]) begin
        frm_ack_ff <= 1'b0;
      end
      if (frm_fire) begin
        frm_ack_ff <= 1'b1;
      end
    end
  end

  // Applied tuning word and one-cycle oscillator reset
  always @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      tuning_word_o <= 32'h00000000;
      osc_reset_o   <= 1'b0;
    end else begin
      if (upd_rise) begin
        tuning_word_o <= staged_word;
      end
      osc_reset_o <= frm_fire;
    end
  end

  // Registered copies of the phase controls
  always @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      osc_start_phase_o <= 16'h0000;
      i_phase_adj_o     <= 10'h000;
      q_phase_adj_o     <= 10'h000;
    end else begin
      // Two's complement phase, 0.0055 degree per step
      osc_start_phase_o <= {ph_hi_ff, ph_lo_ff};
      i_phase_adj_o     <= {ipa_hi_ff, ipa_lo_ff};
      q_phase_adj_o     <= {qpa_hi_ff, qpa_lo_ff};
    end
  end

  // Third filter mode decode
  always @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      third_filter_skip_o     <= 1'b0;
      third_filter_mode_o     <= `NTPO_RST_MODE;
      third_filter_modulate_o <= 1'b0;
    end else begin
      third_filter_skip_o <= fctl_ff[`NTPO_SKIP_BIT];
      third_filter_mode_o <= fctl_ff[`NTPO_MODE_MSB:`NTPO_MODE_LSB];
      // Top mode bit marks the modulated modes
      third_filter_modulate_o <= fctl_ff[`NTPO_MODE_MSB];
    end
  end

  // I sample offset addition, wraps modulo the sample width
  always @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      i_valid_o  <= 1'b0;
      i_sample_o <= {DATA_W{1'b0}};
    end else begin
      i_valid_o <= i_valid_i;
      if (i_valid_i) begin
        i_sample_o <= i_sample_i + i_offset[DATA_W-1:0];
      end
    end
  end

  // Read multiplexer
  always @* begin
    nxt_rdata = 8'h00;
    case (reg_addr_i)
      `NTPO_ADDR_FILT_CTRL: nxt_rdata = fctl_ff;
      `NTPO_ADDR_DEV_ID:   nxt_rdata = `NTPO_DEV_ID_VAL;
      `NTPO_ADDR_TW0:      nxt_rdata = tw_ff[0];
      `NTPO_ADDR_TW1:      nxt_rdata = tw_ff[1];
      `NTPO_ADDR_TW2:      nxt_rdata = tw_ff[2];
      `NTPO_ADDR_TW3:      nxt_rdata = tw_ff[3];
      `NTPO_ADDR_PH_LO:    nxt_rdata = ph_lo_ff;
      `NTPO_ADDR_PH_HI:    nxt_rdata = ph_hi_ff;
      `NTPO_ADDR_UPD: begin
        nxt_rdata[`NTPO_UPD_REQ_BIT] = upd_req_ff;
        nxt_rdata[`NTPO_UPD_ACK_BIT] = upd_ack_ff;
        nxt_rdata[`NTPO_FRM_REQ_BIT] = frm_req_ff;
        nxt_rdata[`NTPO_FRM_ACK_BIT] = frm_ack_ff;
      end
      `NTPO_ADDR_IPA_LO:   nxt_rdata = ipa_lo_ff;
      `NTPO_ADDR_IPA_HI:   nxt_rdata = {6'h00, ipa_hi_ff};
      `NTPO_ADDR_QPA_LO:   nxt_rdata = qpa_lo_ff;
      `NTPO_ADDR_QPA_HI:   nxt_rdata = {6'h00, qpa_hi_ff};
      `NTPO_ADDR_IOFS_LO:  nxt_rdata = iofs_lo_ff;
      `NTPO_ADDR_IOFS_HI:  nxt_rdata = iofs_hi_ff;
      default:             nxt_rdata = 8'h00;
    endcase
  end

  // Registered read data
  always @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      reg_rdata_o <= 8'h00;
    end else if (reg_rd_i) begin
      reg_rdata_o <= nxt_rdata;
    end
  end
endmodule // ntpo_regs
